// ===== core/fadc_lane_decode.sv
// demodulation and ten-level decode of one lane word
`timescale 1ns/1ps
module fadc_lane_decode (
   fadc_lane_if.dec lane
);
   logic [2:0] bits;
   logic range_flag;

   // undo the inversion applied while the modulation level was low
   // undo modulation
   always_comb begin
      lane.plain = lane.mod ? lane.raw : ~lane.raw;
      range_flag = lane.plain[3];
      bits = lane.plain[2:0];
      if (range_flag && bits == 3'h0) begin
         lane.code = fadc_pkg::CODE_BOTTOM;
      end else if (range_flag) begin
         lane.code = fadc_pkg::CODE_TOP;
      end else begin
         lane.code = {1'b0, bits} + 4'h1;
      end
   end
endmodule

// ===== core/fadc_rx_ctrl.sv
// receiver controller: lane alignment, demodulation, lead resolve
`timescale 1ns/1ps
module fadc_rx_ctrl (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic restart_in,
   input wire logic link_clk_in,
   input wire logic [3:0] x_lane_in,
   input wire logic [3:0] y_lane_in,
   output logic inhibit_out,
   output logic mod_out,
   output logic [4:0] delay_out,
   output logic known_sig_out,
   output logic aligned_out,
   output logic lead_y_out,
   output logic [3:0] early_out,
   output logic [3:0] late_out,
   output logic valid_out
);
   fadc_lane_if lane_if [fadc_pkg::LANE_N] ();

   logic lclk_s1_reg, lclk_s2_reg, lclk_s3_reg;
   logic [3:0] lane_s1_reg [fadc_pkg::LANE_N];
   logic [3:0] lane_s2_reg [fadc_pkg::LANE_N];
   logic strobe;
   logic cur_mod;
   logic [3:0] exp_word;
   logic match;

   fadc_pkg::fadc_state_e state_reg, state_next;
   logic [6:0] lfsr_reg, lfsr_next;
   logic [7:0] hist_reg, hist_next;
   logic [2:0] lat_reg, lat_next;
   logic [4:0] dly_reg, dly_next;
   logic [5:0] run_reg, run_next;
   logic [6:0] lcnt_reg, lcnt_next;
   logic signed [7:0] vote_reg, vote_next;
   logic lead_y_reg, lead_y_next;
   logic inhibit_reg, inhibit_next;
   logic mod_reg, mod_next;
   logic known_reg, known_next;
   logic aligned_reg, aligned_next;
   logic [3:0] early_reg, early_next;
   logic [3:0] late_reg, late_next;
   logic valid_reg, valid_next;

   // two-flop synchronisers; the third link clock flop only sees s2
   // sample divided clock
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lclk_s1_reg <= 1'b0;
         lclk_s2_reg <= 1'b0;
         lclk_s3_reg <= 1'b0;
         for (int i = 0; i < fadc_pkg::LANE_N; i++) begin
            lane_s1_reg[i] <= 4'h0;
            lane_s2_reg[i] <= 4'h0;
         end
      end else if (ce_in) begin
         lclk_s1_reg <= link_clk_in;
         lclk_s2_reg <= lclk_s1_reg;
         lclk_s3_reg <= lclk_s2_reg;
         lane_s1_reg[0] <= x_lane_in;
         lane_s1_reg[1] <= y_lane_in;
         for (int i = 0; i < fadc_pkg::LANE_N; i++) begin
            lane_s2_reg[i] <= lane_s1_reg[i];
         end
      end
   end

   // one sample slot per rising edge of the link clock
   assign strobe = lclk_s2_reg & ~lclk_s3_reg;
   // modulation level that the current latency guess pairs with data
   assign cur_mod = hist_reg[lat_reg];

   // one decoder per lane
   genvar g;
   generate
      for (g = 0; g < fadc_pkg::LANE_N; g++) begin : g_lane
         assign lane_if[g].raw = lane_s2_reg[g];
         assign lane_if[g].mod = cur_mod;
         fadc_lane_decode u_dec (
            .lane(lane_if[g])
         );
      end
   endgenerate

   // inhibited zeros arrive inverted whenever modulation was low
   // expect zero data
   always_comb begin
      exp_word = cur_mod ? fadc_pkg::ZERO_WORD : fadc_pkg::ZERO_WORD_INV;
      match = (lane_s2_reg[0] == exp_word) && (lane_s2_reg[1] == exp_word);
   end

   // next-state of the sequencer, generator and output stage
   always_comb begin
      state_next = state_reg;
      lfsr_next = lfsr_reg;
      hist_next = hist_reg;
      lat_next = lat_reg;
      dly_next = dly_reg;
      run_next = run_reg;
      lcnt_next = lcnt_reg;
      vote_next = vote_reg;
      lead_y_next = lead_y_reg;
      inhibit_next = inhibit_reg;
      mod_next = mod_reg;
      known_next = known_reg;
      aligned_next = aligned_reg;
      early_next = early_reg;
      late_next = late_reg;
      valid_next = 1'b0;
      if (restart_in) begin
         state_next = fadc_pkg::FADC_ST_ALIGN;
         inhibit_next = 1'b1;
         known_next = 1'b0;
         aligned_next = 1'b0;
         lat_next = 3'h0;
         dly_next = 5'h0;
         run_next = 6'h0;
         lcnt_next = 7'h0;
         vote_next = 8'sh00;
      end else if (strobe) begin
         lfsr_next = {lfsr_reg[5:0], lfsr_reg[6] ^ lfsr_reg[5]};
         mod_next = lfsr_reg[6] ^ lfsr_reg[5];
         hist_next = {hist_reg[6:0], mod_reg};
         unique case (state_reg)
            fadc_pkg::FADC_ST_ALIGN: begin
               if (match && run_reg == fadc_pkg::ALIGN_LAST) begin
                  state_next = fadc_pkg::FADC_ST_LEAD;
                  inhibit_next = 1'b0;
                  known_next = 1'b1;
                  aligned_next = 1'b1;
                  run_next = 6'h0;
               end else if (match) begin
                  run_next = run_reg + 6'h1;
               end else begin
                  run_next = 6'h0;
                  lat_next = lat_reg + 3'h1;
                  if (lat_reg == fadc_pkg::LAT_LAST) begin
                     dly_next = dly_reg + 5'h1;
                  end
               end
            end
            fadc_pkg::FADC_ST_LEAD: begin
               if (lane_if[0].code < lane_if[1].code) begin
                  vote_next = vote_reg + 8'sh01;
               end else if (lane_if[1].code < lane_if[0].code) begin
                  vote_next = vote_reg - 8'sh01;
               end
               lcnt_next = lcnt_reg + 7'h1;
               if (lcnt_reg == fadc_pkg::LEAD_LAST) begin
                  // a rising known ramp shows the smaller code first
                  lead_y_next = vote_next[7];
                  state_next = fadc_pkg::FADC_ST_RUN;
                  known_next = 1'b0;
               end
            end
            fadc_pkg::FADC_ST_RUN: begin
               early_next = lead_y_reg ? lane_if[1].code : lane_if[0].code;
               late_next = lead_y_reg ? lane_if[0].code : lane_if[1].code;
               valid_next = 1'b1;
            end
            default: begin
               state_next = fadc_pkg::FADC_ST_ALIGN;
               inhibit_next = 1'b1;
            end
         endcase
      end
   end

   // register stage; clock enable low freezes everything
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= fadc_pkg::FADC_ST_ALIGN;
         lfsr_reg <= fadc_pkg::PRBS_SEED;
         hist_reg <= 8'h00;
         lat_reg <= 3'h0;
         dly_reg <= 5'h00;
         run_reg <= 6'h00;
         lcnt_reg <= 7'h00;
         vote_reg <= 8'sh00;
         lead_y_reg <= 1'b0;
         inhibit_reg <= 1'b1;
         mod_reg <= 1'b0;
         known_reg <= 1'b0;
         aligned_reg <= 1'b0;
         early_reg <= 4'h0;
         late_reg <= 4'h0;
         valid_reg <= 1'b0;
      end else if (ce_in) begin
         state_reg <= state_next;
         lfsr_reg <= lfsr_next;
         hist_reg <= hist_next;
         lat_reg <= lat_next;
         dly_reg <= dly_next;
         run_reg <= run_next;
         lcnt_reg <= lcnt_next;
         vote_reg <= vote_next;
         lead_y_reg <= lead_y_next;
         inhibit_reg <= inhibit_next;
         mod_reg <= mod_next;
         known_reg <= known_next;
         aligned_reg <= aligned_next;
         early_reg <= early_next;
         late_reg <= late_next;
         valid_reg <= valid_next;
      end
   end

   // outputs straight from flops
   assign inhibit_out = inhibit_reg;
   assign mod_out = mod_reg;
   assign delay_out = dly_reg;
   assign known_sig_out = known_reg;
   assign aligned_out = aligned_reg;
   assign lead_y_out = lead_y_reg;
   assign early_out = early_reg;
   assign late_out = late_reg;
   assign valid_out = valid_reg;

   // checks on the sequencer and decoders
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rst_n_in);

   sequence s_align_done;
      ce_in && !restart_in && strobe && match &&
         run_reg == fadc_pkg::ALIGN_LAST &&
         state_reg == fadc_pkg::FADC_ST_ALIGN;
   endsequence

   sequence s_lead_done;
      ce_in && !restart_in && strobe && lcnt_reg == fadc_pkg::LEAD_LAST &&
         state_reg == fadc_pkg::FADC_ST_LEAD;
   endsequence

   a_inhibit_in_align: assert property (
      state_reg == fadc_pkg::FADC_ST_ALIGN |-> inhibit_out && !aligned_out)
      else $error("inhibit low while aligning");
   a_release_inhibit: assert property (
      s_align_done |=> !inhibit_out && known_sig_out &&
         state_reg == fadc_pkg::FADC_ST_LEAD)
      else $error("inhibit not released after alignment");
   a_demod_invert: assert property (
      !lane_if[0].mod |-> lane_if[0].plain == ~lane_if[0].raw)
      else $error("modulation not removed");
   a_prbs_step: assert property (
      ce_in && strobe && !restart_in |=>
         mod_out == lfsr_reg[0] && hist_reg[0] == $past(mod_out))
      else $error("modulation does not follow generator");
   a_lead_decide: assert property (
      s_lead_done |=> state_reg == fadc_pkg::FADC_ST_RUN &&
         !known_sig_out && lead_y_out == vote_reg[7])
      else $error("lead lane not resolved");
   a_restart_search: assert property (
      ce_in && restart_in |=> inhibit_out && !aligned_out &&
         delay_out == 5'h00 && state_reg == fadc_pkg::FADC_ST_ALIGN)
      else $error("restart did not begin a new search");
   a_delay_sweep: assert property (
      ce_in && !restart_in && strobe && !match &&
         lat_reg == fadc_pkg::LAT_LAST &&
         state_reg == fadc_pkg::FADC_ST_ALIGN |=>
         delay_out == $past(delay_out) + 5'h1 && lat_reg == 3'h0)
      else $error("delay not stepped after all latencies");
   a_bottom_code: assert property (
      lane_if[1].plain == 4'h8 |-> lane_if[1].code == 4'h0)
      else $error("bottom code wrong");
   a_normal_code: assert property (
      !lane_if[0].plain[3] |->
         lane_if[0].code == {1'b0, lane_if[0].plain[2:0]} + 4'h1)
      else $error("normal code wrong");
   a_top_code: assert property (
      lane_if[0].plain == 4'hf |-> lane_if[0].code == 4'h9)
      else $error("top code wrong");
   a_run_output: assert property (
      ce_in && !restart_in && strobe &&
         state_reg == fadc_pkg::FADC_ST_RUN |=>
         valid_out ##1 (!valid_out || !$past(ce_in)))
      else $error("run sample not presented");
endmodule

// ===== shared/fadc_lane_if.sv
// carrier between the receiver core and a lane decoder
`timescale 1ns/1ps
interface fadc_lane_if;
   logic [3:0] raw;
   logic mod;
   logic [3:0] plain;
   logic [3:0] code;
   modport ctrl (output raw, output mod, input plain, input code);
   modport dec (input raw, input mod, output plain, output code);
endinterface

// ===== shared/fadc_pkg.sv
// constants and types for the flash converter lane receiver
package fadc_pkg;
   // lane word: bit 3 is range_flag, bits 2:0 are the data bits
   localparam int LANE_W = 4;
   localparam int CODE_W = 4;
   localparam int LANE_N = 2;
   // modulation history depth and latency candidate width
   localparam int HIST_N = 8;
   localparam int LAT_W = 3;
   localparam logic [2:0] LAT_LAST = 3'h7;
   // external delay stage control width
   localparam int DLY_W = 5;
   // matching samples needed to call the lanes aligned
   localparam logic [5:0] ALIGN_LAST = 6'h1f;
   // known-signal samples used to vote on the leading lane
   localparam logic [6:0] LEAD_LAST = 7'h3f;
   // prbs7 modulation generator
   localparam int PRBS_W = 7;
   localparam logic [6:0] PRBS_SEED = 7'h01;
   // ten-level code points
   localparam logic [3:0] CODE_BOTTOM = 4'h0;
   localparam logic [3:0] CODE_TOP = 4'h9;
   // expected lane word for inhibited zeros
   localparam logic [3:0] ZERO_WORD = 4'h0;
   localparam logic [3:0] ZERO_WORD_INV = 4'hf;
   typedef enum logic [1:0] {
      FADC_ST_ALIGN = 2'b00,
      FADC_ST_LEAD = 2'b01,
      FADC_ST_RUN = 2'b10
   } fadc_state_e;
endpackage

// ===== tb/fadc_conv_model.sv
// behavioural flash converter: inhibit, modulation, demux and link clock
`timescale 1ns/1ps
module fadc_conv_model (
   input wire logic inhibit_in,
   input wire logic mod_in,
   input wire logic [4:0] delay_in,
   input wire logic lead_y_in,
   input wire logic [3:0] early_lvl_in,
   input wire logic [3:0] late_lvl_in,
   output logic link_clk_out,
   output logic [3:0] x_lane_out,
   output logic [3:0] y_lane_out
);
   logic [3:0] ew;
   logic [3:0] lw;
   logic flip;

   // level 0..9 to lane word {range_flag, data bits}
   // flag set only outside the ladder
   function automatic logic [3:0] enc(input logic [3:0] lvl);
      if (lvl == 4'h0) return 4'h8;
      if (lvl >= 4'h9) return 4'hf;
      return {1'b0, 3'(lvl - 4'h1)};
   endfunction

   // link clock is the divided converter clock, free running
   initial begin
      link_clk_out = 1'b0;
      x_lane_out = 4'h0;
      y_lane_out = 4'h0;
      flip = 1'b0;
      #1003;
      forever #160 link_clk_out = ~link_clk_out;
   end

   // sample inputs at link rise; odd phase keeps clear of mclk edges
   always @(posedge link_clk_out) begin
      // zeros forced ahead of modulation and demux
      ew = inhibit_in ? 4'h0 : enc(early_lvl_in);
      lw = inhibit_in ? 4'h0 : enc(late_lvl_in);
      // outputs inverted while modulation is low
      if (!mod_in) begin
         ew = ~ew;
         lw = ~lw;
      end
      // short delay retimes modulation badly, so words garble
      flip = ~flip;
      if (delay_in < 5'h2 && flip) begin
         ew = ~ew;
         lw = ~lw;
      end
   end

   // present at link fall so lanes are settled around the next rise
   always @(negedge link_clk_out) begin
      // either lane may carry the earlier sample
      x_lane_out = lead_y_in ? lw : ew;
      y_lane_out = lead_y_in ? ew : lw;
   end
endmodule

// ===== tb/fadc_rx_ctrl_tb_top.sv
// self-checking bench for the lane receiver controller
`timescale 1ns/1ps
module fadc_rx_ctrl_tb_top;
   logic mclk_in, rst_n_in, ce_in, restart_in, link_clk;
   logic [3:0] x_lane, y_lane, early, late, early_lvl, late_lvl;
   logic inhibit, mod_s, known_sig, aligned, lead_y, valid;
   logic [4:0] delay;
   logic lead_y_m, lk_q, run_chk;
   logic [7:0] lvl_q[$];
   logic [7:0] frz;
   int error_cnt, n_tests, seed, r, r2, n_val;

   fadc_rx_ctrl u_fadc_rx_ctrl (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .ce_in(ce_in), .restart_in(restart_in), .link_clk_in(link_clk),
      .x_lane_in(x_lane), .y_lane_in(y_lane), .inhibit_out(inhibit),
      .mod_out(mod_s), .delay_out(delay), .known_sig_out(known_sig),
      .aligned_out(aligned), .lead_y_out(lead_y), .early_out(early),
      .late_out(late), .valid_out(valid));

   fadc_conv_model u_fadc_conv_model (.inhibit_in(inhibit),
      .mod_in(mod_s), .delay_in(delay), .lead_y_in(lead_y_m),
      .early_lvl_in(early_lvl), .late_lvl_in(late_lvl),
      .link_clk_out(link_clk), .x_lane_out(x_lane), .y_lane_out(y_lane));

   initial begin
      mclk_in = 1'b0;
      forever #20 mclk_in = ~mclk_in;
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic close_out;
      if (error_cnt == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // bounded wait on aligned (sel 0) or known signal (sel 1)
   task automatic wait_sig(input int sel, input logic lvl);
      int i;
      for (i = 0; i < 12000; i++) begin
         @(negedge mclk_in);
         if ((sel == 0 ? aligned : known_sig) === lvl) break;
      end
      check(8'(sel == 0 ? aligned : known_sig), 8'(lvl));
   endtask

   // one full search: align, lead vote, then checked live samples
   task automatic run_pass(input logic ly);
      wait_sig(0, 1'b1);
      check(8'(inhibit), 8'h0);
      check(8'(delay >= 5'h2), 8'h1);
      check(8'(known_sig), 8'h1);
      wait_sig(1, 1'b0);
      check(8'(lead_y), 8'(ly));
      @(posedge mclk_in);
      run_chk <= 1'b1;
      n_val = 0;
      repeat (320) @(posedge mclk_in);
      run_chk <= 1'b0;
      check(8'(n_val >= 39), 8'h1);
   endtask

   // new levels just after each link rise; ramp while known is asked
   always @(posedge mclk_in) begin
      lk_q <= link_clk;
      if (link_clk && !lk_q) begin
         r = $unsigned($random(seed)) % 10;
         r2 = $unsigned($random(seed)) % 10;
         early_lvl <= known_sig ? 4'(r % 9) : 4'(r);
         late_lvl <= known_sig ? 4'(r % 9 + 1) : 4'(r2);
      end
   end

   // reference: levels the converter captured, one entry per slot
   always @(posedge link_clk) begin
      lvl_q.push_back({early_lvl, late_lvl});
      if (lvl_q.size() > 4) lvl_q.pop_front();
   end

   // each result decodes the pair captured one slot before the last
   always @(posedge mclk_in) begin
      if (valid === 1'b1) begin
         n_val++;
         if (run_chk && lvl_q.size() >= 2) begin
            frz = lvl_q[lvl_q.size() - 2];
            check(8'(early), 8'(frz[7:4]));
            check(8'(late), 8'(frz[3:0]));
         end
      end
   end

   // hang guard, far beyond two full searches
   initial begin
      #800000;
      error_cnt++;
      close_out;
   end

   initial begin
      seed = 41;
      error_cnt = 0;
      n_tests = 0;
      n_val = 0;
      rst_n_in = 1'b0;
      ce_in = 1'b1;
      restart_in = 1'b0;
      lead_y_m = 1'b0;
      run_chk = 1'b0;
      lk_q = 1'b0;
      early_lvl = 4'h0;
      late_lvl = 4'h0;
      repeat (5) @(posedge mclk_in);
      @(negedge mclk_in);
      check({inhibit, known_sig, aligned, delay}, 8'h80);
      check(8'(valid), 8'h0);
      @(posedge mclk_in);
      rst_n_in <= 1'b1;
      run_pass(1'b0);
      // clock enable low freezes every output, even with slots passing
      // drop enable on the edge that ends a valid pulse, so valid freezes low
      @(posedge mclk_in);
      while (valid !== 1'b1) @(posedge mclk_in);
      ce_in <= 1'b0;
      @(negedge mclk_in);
      frz = {mod_s, lead_y, known_sig, inhibit, early};
      n_val = 0;
      repeat (32) @(posedge mclk_in);
      check({mod_s, lead_y, known_sig, inhibit, early}, frz);
      check(8'(n_val), 8'h0);
      ce_in <= 1'b1;
      // restart with lane Y leading; old lead holds until re-decided
      lead_y_m <= 1'b1;
      restart_in <= 1'b1;
      @(posedge mclk_in);
      restart_in <= 1'b0;
      @(negedge mclk_in);
      check({inhibit, aligned, lead_y, delay}, 8'h80);
      run_pass(1'b1);
      close_out;
   end
endmodule
